//--- inc/sbth_defs.svh
// offsets, field positions, reset values and timing counts for the handshake
`ifndef SBTH_DEFS_SVH
`define SBTH_DEFS_SVH
`define SBTH_OFF_CTRL 8'h00
`define SBTH_OFF_STAT 8'h04
`define SBTH_OFF_IRQ_STAT 8'h08
`define SBTH_OFF_IRQ_MASK 8'h0C
`define SBTH_OFF_TX_BASE 8'h40
`define SBTH_OFF_RX_BASE 8'h80
`define SBTH_BIT_TXREQ 0
`define SBTH_BIT_RXCON 1
`define SBTH_BIT_INIT 2
`define SBTH_BIT_BUFF 3
`define SBTH_LEN_LSB 4
`define SBTH_LEN_MSB 15
`define SBTH_ARR_BYTES 16
`define SBTH_FIFO_DEPTH 16
`define SBTH_CYCLE_NS 1000
`define SBTH_CLK_NS 10
`define SBTH_CYCLE_CNT (`SBTH_CYCLE_NS / `SBTH_CLK_NS)
`define SBTH_INIT_CYCLES 4
`define SBTH_CTRL_RESET 16'h0000
`define SBTH_IRQ_TX 0
`define SBTH_IRQ_RX 1
`define SBTH_IRQ_INIT 2
`define SBTH_IRQ_FULL 3
`endif

//--- inc/sbth_pkg.sv
// types shared by the handshake block
package sbth_pkg;
    typedef enum logic [1:0] {
        SBTH_RUN,
        SBTH_INIT_BUSY,
        SBTH_INIT_DONE
    } sbth_init_state_t;
    typedef logic [7:0] sbth_byte_t;
endpackage

//--- src/sbth_cycle_tick.sv
// process-data cycle divider producing a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
`include "sbth_defs.svh"
module sbth_cycle_tick (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    localparam int CNT_MAX = `SBTH_CYCLE_CNT - 1;
    logic [15:0] cnt_reg;
    // counts up one cycle period, pulses at wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 16'h0000;
        end else if (cnt_reg == 16'(CNT_MAX)) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
    assign tick = (cnt_reg == 16'(CNT_MAX));
endmodule // sbth_cycle_tick
`default_nettype wire

//--- src/sbth_handshake.sv
// serial buffer toggle handshake with AXI4-Lite register access
// Function
// - full receive fifo sets buffer-full flag and drops further bytes
// - init-acknowledge flag goes high when initialization finishes
// - init-acknowledge flag returns low when ready for exchange again
// - rx ready toggle inverts when receive array holds counted bytes
// - no new receive block until consumed toggle matches ready toggle
// - tx accepted toggle inverts once transmit bytes are taken over
// - init request blocks traffic, clears fifo pointers, then acknowledges
// - byte counts sit in bits 4 to 15 of control and status words
`timescale 1ns/1ps
`default_nettype none
`include "sbth_defs.svh"
module sbth_handshake
    import sbth_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] ser_rx_data,
    input wire logic ser_rx_valid,
    output logic [7:0] ser_tx_data,
    output logic ser_tx_valid,
    input wire logic ser_tx_ready,
    output logic irq
);
    localparam int DEPTH = `SBTH_FIFO_DEPTH;
    localparam int NB = `SBTH_ARR_BYTES;

    // register state
    logic [15:0] control_word_reg;
    logic [3:0] irq_stat_reg, irq_mask_reg;
    logic tx_accepted_toggle_reg, rx_ready_toggle_reg;
    logic init_done_flag_reg, buf_full_reg;
    logic [11:0] rx_byte_count_reg;
    sbth_byte_t tx_byte_array [NB];
    sbth_byte_t rx_byte_array [NB];
    sbth_byte_t fifo_mem [DEPTH];
    logic [4:0] wr_ptr_reg, rd_ptr_reg;
    sbth_init_state_t init_state_reg;
    logic [2:0] init_cnt_reg;
    logic [4:0] tx_left_reg, tx_idx_reg;
    logic tx_busy_reg;
    logic [7:0] ser_rx_d1_reg, ser_rx_d2_reg;
    logic ser_rx_v1_reg, ser_rx_v2_reg, ser_rx_v3_reg;
    logic tick;

    sbth_cycle_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    // control word fields
    wire tx_req_toggle = control_word_reg[`SBTH_BIT_TXREQ];
    wire rx_consumed_toggle = control_word_reg[`SBTH_BIT_RXCON];
    wire init_request = control_word_reg[`SBTH_BIT_INIT];
    wire [11:0] tx_byte_count =
        control_word_reg[`SBTH_LEN_MSB:`SBTH_LEN_LSB];
    wire [15:0] status_word = {rx_byte_count_reg, buf_full_reg,
        init_done_flag_reg, rx_ready_toggle_reg,
        tx_accepted_toggle_reg};
    wire blocked = init_request | (init_state_reg != SBTH_RUN);

    // fifo status
    wire [4:0] fifo_used = wr_ptr_reg - rd_ptr_reg;
    wire fifo_full = (fifo_used == 5'(DEPTH));
    wire fifo_empty = (fifo_used == 5'h00);

    // toggle detection on the cycle tick
    wire tx_new = tick & !blocked & !tx_busy_reg
        & (tx_req_toggle != tx_accepted_toggle_reg);
    wire rx_free = (rx_consumed_toggle == rx_ready_toggle_reg);
    wire rx_post = tick & !blocked & rx_free & !fifo_empty;
    wire [4:0] rx_take = (fifo_used > 5'(NB)) ? 5'(NB) : fifo_used;
    wire rx_push = ser_rx_v2_reg & !ser_rx_v3_reg
        & !blocked & !fifo_full;
    wire tx_done = tx_busy_reg & (tx_left_reg == 5'h00);

    // axi write decode
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    assign s_axi_awready = !aw_held_reg & !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg & !s_axi_bvalid;
    wire wr_go = aw_held_reg & w_held_reg & !s_axi_bvalid;
    wire wr_ctrl = wr_go & (aw_addr_reg == `SBTH_OFF_CTRL);
    wire wr_istat = wr_go & (aw_addr_reg == `SBTH_OFF_IRQ_STAT);
    wire wr_imask = wr_go & (aw_addr_reg == `SBTH_OFF_IRQ_MASK);
    wire wr_tx = wr_go && aw_addr_reg >= `SBTH_OFF_TX_BASE
        && aw_addr_reg < (`SBTH_OFF_TX_BASE + 8'(4 * NB));
    wire wr_ok = wr_ctrl | wr_istat | wr_imask | wr_tx;
    wire [3:0] tx_wi = 4'((aw_addr_reg - `SBTH_OFF_TX_BASE) >> 2); // one per word

    // axi write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control, mask and transmit array writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_word_reg <= `SBTH_CTRL_RESET;
            irq_mask_reg <= 4'h0;
        end else begin
            if (wr_ctrl && w_strb_reg[0])
                control_word_reg[7:0] <= w_data_reg[7:0];
            if (wr_ctrl && w_strb_reg[1])
                control_word_reg[15:8] <= w_data_reg[15:8];
            if (wr_imask && w_strb_reg[0])
                irq_mask_reg <= w_data_reg[3:0];
        end
    end
    always_ff @(posedge aclk) begin
        if (wr_tx && w_strb_reg[0])
            tx_byte_array[tx_wi] <= w_data_reg[7:0];
    end

    // axi read path
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire rd_rx = ra >= `SBTH_OFF_RX_BASE
        && ra < (`SBTH_OFF_RX_BASE + 8'(4 * NB));
    wire [3:0] rx_ri = 4'((ra - `SBTH_OFF_RX_BASE) >> 2); // one per word
    wire rd_known = (ra == `SBTH_OFF_CTRL) | (ra == `SBTH_OFF_STAT)
        | (ra == `SBTH_OFF_IRQ_STAT) | (ra == `SBTH_OFF_IRQ_MASK) | rd_rx;
    wire [31:0] rd_mux =
        (ra == `SBTH_OFF_CTRL) ? {16'h0000, control_word_reg} :
        (ra == `SBTH_OFF_STAT) ? {16'h0000, status_word} :
        (ra == `SBTH_OFF_IRQ_STAT) ? {28'h0000000, irq_stat_reg} :
        (ra == `SBTH_OFF_IRQ_MASK) ? {28'h0000000, irq_mask_reg} :
        rd_rx ? {24'h000000, rx_byte_array[rx_ri]} : 32'h00000000;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // serial receive input synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_rx_v1_reg <= 1'b0;
            ser_rx_v2_reg <= 1'b0;
            ser_rx_v3_reg <= 1'b0;
            ser_rx_d1_reg <= 8'h00;
            ser_rx_d2_reg <= 8'h00;
        end else begin
            ser_rx_v1_reg <= ser_rx_valid;
            ser_rx_v2_reg <= ser_rx_v1_reg;
            ser_rx_v3_reg <= ser_rx_v2_reg; // previous level for edge detect
            ser_rx_d1_reg <= ser_rx_data;
            ser_rx_d2_reg <= ser_rx_d1_reg;
        end
    end

    // receive fifo storage
    always_ff @(posedge aclk) begin
        if (rx_push)
            fifo_mem[wr_ptr_reg[3:0]] <= ser_rx_d2_reg;
    end

    // receive block copy into the receive array
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_rx_copy
            always_ff @(posedge aclk) begin
                if (rx_post && 5'(gi) < rx_take)
                    rx_byte_array[gi] <= fifo_mem[4'(rd_ptr_reg + 5'(gi))];
            end
        end
    endgenerate

    // fifo pointers, receive toggle and full flag
    always_ff @(posedge aclk) begin
        if (!aresetn || init_state_reg == SBTH_INIT_BUSY) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            buf_full_reg <= 1'b0;
        end else begin
            if (rx_push)
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            if (rx_post)
                rd_ptr_reg <= rd_ptr_reg + rx_take;
            buf_full_reg <= fifo_full & !rx_post;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ready_toggle_reg <= 1'b0;
            rx_byte_count_reg <= 12'h000;
        end else if (rx_post) begin
            rx_ready_toggle_reg <= !rx_ready_toggle_reg;
            rx_byte_count_reg <= 12'(rx_take);
        end
    end

    // transmit take-over and serial output
    always_ff @(posedge aclk) begin
        if (!aresetn || blocked) begin
            tx_busy_reg <= 1'b0;
            tx_left_reg <= 5'h00;
            tx_idx_reg <= 5'h00;
        end else if (tx_new) begin
            tx_busy_reg <= 1'b1;
            tx_left_reg <= (tx_byte_count > 12'(NB)) ? 5'(NB)
                : 5'(tx_byte_count);
            tx_idx_reg <= 5'h00;
        end else if (tx_done) begin
            tx_busy_reg <= 1'b0;
        end else if (tx_busy_reg && ser_tx_ready) begin
            tx_left_reg <= tx_left_reg - 5'h01;
            tx_idx_reg <= tx_idx_reg + 5'h01;
        end
    end
    assign ser_tx_valid = tx_busy_reg & (tx_left_reg != 5'h00);
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ser_tx_data <= 8'h00;
        else if (tx_new)
            ser_tx_data <= tx_byte_array[0]; // first byte ready as valid rises
        else
            ser_tx_data <= tx_byte_array[tx_idx_reg[3:0] + 4'(ser_tx_valid
                & ser_tx_ready)];
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            tx_accepted_toggle_reg <= 1'b0;
        else if (tx_done)
            tx_accepted_toggle_reg <= !tx_accepted_toggle_reg;
    end

    // initialization sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_state_reg <= SBTH_RUN;
            init_cnt_reg <= 3'h0;
            init_done_flag_reg <= 1'b0;
        end else begin
            unique case (init_state_reg)
                SBTH_RUN: if (init_request) begin
                    init_state_reg <= SBTH_INIT_BUSY;
                    init_cnt_reg <= 3'(`SBTH_INIT_CYCLES - 1);
                end
                SBTH_INIT_BUSY: if (init_cnt_reg == 3'h0) begin
                    init_state_reg <= SBTH_INIT_DONE;
                    init_done_flag_reg <= 1'b1;
                end else begin
                    init_cnt_reg <= init_cnt_reg - 3'h1;
                end
                SBTH_INIT_DONE: if (!init_request) begin
                    init_state_reg <= SBTH_RUN;
                    init_done_flag_reg <= 1'b0;
                end
            endcase
        end
    end

    // sticky interrupt flags, set wins over write-one clear
    wire [3:0] irq_ev = {rx_push & fifo_used == 5'(DEPTH - 1),
        init_state_reg == SBTH_INIT_BUSY && init_cnt_reg == 3'h0,
        rx_post, tx_done};
    wire [3:0] irq_clr = (wr_istat && w_strb_reg[0]) ? w_data_reg[3:0]
        : 4'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_stat_reg <= 4'h0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // checks
    property p_full_flag;
        @(posedge aclk) disable iff (!aresetn)
        (fifo_full && !rx_post && init_state_reg != SBTH_INIT_BUSY)
            |=> buf_full_reg;
    endproperty
    a_full_flag: assert property (p_full_flag)
        else $error("full flag not set");
    property p_no_push_full;
        @(posedge aclk) disable iff (!aresetn)
        fifo_full && !rx_post |=> fifo_used == 5'(DEPTH) || $past(blocked);
    endproperty
    a_no_push_full: assert property (p_no_push_full)
        else $error("byte stored into full fifo");
    property p_init_ack;
        @(posedge aclk) disable iff (!aresetn)
        $rose(init_request) && init_state_reg == SBTH_RUN
            |-> ##[1:8] init_done_flag_reg;
    endproperty
    a_init_ack: assert property (p_init_ack)
        else $error("init not acknowledged");
    property p_init_release;
        @(posedge aclk) disable iff (!aresetn)
        init_done_flag_reg && !init_request |=> !init_done_flag_reg;
    endproperty
    a_init_release: assert property (p_init_release)
        else $error("init ack not released");
    property p_rx_toggle;
        @(posedge aclk) disable iff (!aresetn)
        $changed(rx_ready_toggle_reg) |-> $past(rx_free)
            && rx_byte_count_reg != 12'h000;
    endproperty
    a_rx_toggle: assert property (p_rx_toggle)
        else $error("bad receive toggle");
    property p_rx_hold;
        @(posedge aclk) disable iff (!aresetn)
        !rx_free |=> $stable(rx_byte_count_reg);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("receive block overwritten");
    property p_tx_ack;
        @(posedge aclk) disable iff (!aresetn)
        $changed(tx_accepted_toggle_reg) |-> $past(tx_done);
    endproperty
    a_tx_ack: assert property (p_tx_ack)
        else $error("transmit toggle without take-over");
    property p_init_block;
        @(posedge aclk) disable iff (!aresetn)
        init_state_reg == SBTH_INIT_BUSY |=> fifo_used == 5'h00
            && !ser_tx_valid;
    endproperty
    a_init_block: assert property (p_init_block)
        else $error("traffic during init");
    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        irq_ev != 4'h0 |=> (irq_stat_reg & $past(irq_ev)) == $past(irq_ev);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt event not latched");
    c_rx: cover property (@(posedge aclk) rx_post);
    c_tx: cover property (@(posedge aclk) tx_done);
    c_full: cover property (@(posedge aclk) buf_full_reg);
    c_init: cover property (@(posedge aclk) $fell(init_done_flag_reg));
endmodule // sbth_handshake
`default_nettype wire

//--- testbench/sbth_serial_peer.sv
// far-side serial peer: byte source and stalling byte sink
`timescale 1ns/1ps
`default_nettype none
module sbth_serial_peer (
    input wire logic aclk,
    input wire logic [7:0] ser_tx_data,
    input wire logic ser_tx_valid,
    output logic ser_tx_ready,
    output logic [7:0] ser_rx_data,
    output logic ser_rx_valid
);
    logic [7:0] tx_seen[$];
    logic [1:0] stall_cnt;
    initial begin
        ser_tx_ready = 1'b0;
        ser_rx_data = 8'hA5;
        ser_rx_valid = 1'b0;
        stall_cnt = 2'h0;
    end
    // sink takes one byte in three cycles, stalling in between
    always @(posedge aclk) begin
        if (ser_tx_valid && ser_tx_ready) begin
            tx_seen.push_back(ser_tx_data);
        end
        stall_cnt <= (stall_cnt == 2'h2) ? 2'h0 : stall_cnt + 2'h1;
        ser_tx_ready <= (stall_cnt == 2'h2);
    end
    // data held around the valid rise, then scrambled once released
    task automatic send_byte(input logic [7:0] b);
        @(posedge aclk);
        ser_rx_data <= b;
        repeat (3) @(posedge aclk);
        ser_rx_valid <= 1'b1;
        repeat (4) @(posedge aclk);
        ser_rx_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        ser_rx_data <= ~b;
    endtask
endmodule // sbth_serial_peer
`default_nettype wire

//--- testbench/test_sbth_handshake.sv
// self-checking bench for the serial buffer toggle handshake
`timescale 1ns/1ps
`default_nettype none
`include "sbth_defs.svh"
module test_sbth_handshake;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ser_rx_data, ser_tx_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, ser_rx_valid, ser_tx_valid;
    logic ser_tx_ready, irq, tx_tog, rx_con;
    int errors, samples_checked, cycles;

    // device under test and its serial peer
    sbth_handshake u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ser_rx_data(ser_rx_data),
        .ser_rx_valid(ser_rx_valid), .ser_tx_data(ser_tx_data),
        .ser_tx_valid(ser_tx_valid), .ser_tx_ready(ser_tx_ready), .irq(irq));
    sbth_serial_peer u_peer (.aclk(aclk), .ser_tx_data(ser_tx_data),
        .ser_tx_valid(ser_tx_valid), .ser_tx_ready(ser_tx_ready),
        .ser_rx_data(ser_rx_data), .ser_rx_valid(ser_rx_valid));

    // 100 MHz clock
    initial aclk = 1'b0;
    always #5 aclk = ~aclk;

    // hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk); // idle edge before the next request
    endtask

    // one read, result left in rd and rsp
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk); // idle edge before the next request
    endtask

    task automatic set_ctrl(input logic [11:0] cnt, input logic init);
        axi_wr(`SBTH_OFF_CTRL, {16'h0, cnt, 1'b0, init, rx_con, tx_tog});
    endtask

    // poll the status word until a bit reaches a value, bounded
    task automatic wait_stat(input int b, input logic v);
        int n;
        n = 0;
        axi_rd(`SBTH_OFF_STAT);
        while (rd[b] !== v && n < 300) begin
            axi_rd(`SBTH_OFF_STAT);
            n++;
        end
    endtask

    task automatic rx_check(input int n, input logic [7:0] first);
        for (int i = 0; i < n; i++) begin
            axi_rd(`SBTH_OFF_RX_BASE + 8'(4 * i));
            chk("rx byte", 32'(first + 8'(i)), {24'h0, rd[7:0]});
        end
    endtask

    // offer n bytes and see them leave on the serial side
    task automatic tx_block(input int n);
        int base;
        base = u_peer.tx_seen.size();
        for (int i = 0; i < n; i++) begin
            axi_wr(`SBTH_OFF_TX_BASE + 8'(4 * i), {24'h0, 8'hA0 + 8'(i)});
        end
        tx_tog = ~tx_tog;
        set_ctrl(12'(n), 1'b0);
        wait_stat(`SBTH_BIT_TXREQ, tx_tog);
        chk("tx accepted", 32'(tx_tog), 32'(rd[0]));
        chk("tx count", n, u_peer.tx_seen.size() - base);
        for (int i = 0; i < n; i++) begin
            chk("tx byte", 8'hA0 + i, u_peer.tx_seen[base + i]);
        end
    endtask

    task automatic test_reset();
        axi_rd(`SBTH_OFF_CTRL);
        chk("ctrl reset", `SBTH_CTRL_RESET, rd);
        axi_rd(`SBTH_OFF_STAT);
        chk("status reset", 32'h0, rd);
        axi_rd(8'h10);
        chk("unmapped read", 32'h2, 32'(rsp));
        axi_wr(8'h10, 32'h0000FFFF);
        chk("unmapped write", 32'h2, 32'(rsp));
        s_axi_wstrb <= 4'h2;
        axi_wr(`SBTH_OFF_CTRL, 32'h0000FF07);
        axi_rd(`SBTH_OFF_CTRL);
        chk("ctrl lane 1 only", 32'h0000FF00, rd);
        s_axi_wstrb <= 4'hF;
        axi_wr(`SBTH_OFF_CTRL, 32'h0);
        chk("irq idle", 32'h0, 32'(irq));
    endtask

    // transfers of 1, 16 and 0 bytes; interrupt mask and clear
    task automatic test_tx();
        tx_block(1);
        chk("irq masked", 32'h0, 32'(irq));
        axi_rd(`SBTH_OFF_IRQ_STAT);
        chk("irq tx status", 32'h1, 32'(rd[`SBTH_IRQ_TX]));
        axi_wr(`SBTH_OFF_IRQ_MASK, 32'h1);
        @(posedge aclk);
        chk("irq raised", 32'h1, 32'(irq));
        axi_wr(`SBTH_OFF_IRQ_STAT, 32'h1);
        @(posedge aclk);
        chk("irq cleared", 32'h0, 32'(irq));
        axi_wr(`SBTH_OFF_IRQ_MASK, 32'h0);
        tx_block(16);
        tx_block(0);
    endtask

    // receive block, then a block held back until consumed
    task automatic test_rx();
        @(posedge aclk iff u_dut.tick); // whole block lands between ticks
        for (int i = 0; i < 3; i++) u_peer.send_byte(8'h51 + 8'(i));
        wait_stat(`SBTH_BIT_RXCON, ~rx_con);
        chk("rx ready", 32'(!rx_con), 32'(rd[1]));
        chk("rx count", 32'h3, 32'(rd[15:4]));
        rx_check(3, 8'h51);
        u_peer.send_byte(8'h61);
        u_peer.send_byte(8'h62);
        repeat (300) @(posedge aclk);
        axi_rd(`SBTH_OFF_STAT);
        chk("rx held", 32'(!rx_con), 32'(rd[1]));
        chk("rx count held", 32'h3, 32'(rd[15:4]));
        rx_con = ~rx_con;
        set_ctrl(12'h0, 1'b0);
        wait_stat(`SBTH_BIT_RXCON, ~rx_con);
        chk("rx count next", 32'h2, 32'(rd[15:4]));
        rx_check(2, 8'h61);
    endtask

    // fill the receive fifo while a block is pending
    task automatic test_full();
        for (int i = 0; i < 16; i++) u_peer.send_byte(8'h70 + 8'(i));
        axi_rd(`SBTH_OFF_STAT);
        chk("buffer full", 32'h1, 32'(rd[`SBTH_BIT_BUFF]));
        u_peer.send_byte(8'hE0);
        u_peer.send_byte(8'hE1);
        rx_con = ~rx_con;
        set_ctrl(12'h0, 1'b0);
        wait_stat(`SBTH_BIT_RXCON, ~rx_con);
        chk("full count", 32'h10, 32'(rd[15:4]));
        rx_check(16, 8'h70);
        rx_con = ~rx_con;
        set_ctrl(12'h0, 1'b0);
        repeat (300) @(posedge aclk);
        axi_rd(`SBTH_OFF_STAT);
        chk("dropped bytes", 32'(rx_con), 32'(rd[1]));
        chk("buffer free", 32'h0, 32'(rd[`SBTH_BIT_BUFF]));
    endtask

    // init request clears a waiting byte and is acknowledged
    task automatic test_init();
        u_peer.send_byte(8'h33);
        wait_stat(`SBTH_BIT_RXCON, ~rx_con);
        u_peer.send_byte(8'h34);
        set_ctrl(12'h0, 1'b1);
        wait_stat(`SBTH_BIT_INIT, 1'b1);
        chk("init done", 32'h1, 32'(rd[`SBTH_BIT_INIT]));
        set_ctrl(12'h0, 1'b0);
        wait_stat(`SBTH_BIT_INIT, 1'b0);
        chk("init released", 32'h0, 32'(rd[`SBTH_BIT_INIT]));
        rx_con = ~rx_con;
        set_ctrl(12'h0, 1'b0);
        repeat (300) @(posedge aclk);
        axi_rd(`SBTH_OFF_STAT);
        chk("fifo cleared", 32'(rx_con), 32'(rd[1]));
    endtask

    // reset, then the scenarios in turn
    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        tx_tog = 1'b0;
        rx_con = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_tx();
        test_rx();
        test_full();
        test_init();
        give_verdict();
    end
endmodule // test_sbth_handshake
`default_nettype wire
